// ===== motor_stop_consts.svh
// Register offsets, field positions and step sizes of the motor stop block
`ifndef MOTOR_STOP_CONSTS_SVH
`define MOTOR_STOP_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_BRAKE_TIME 8'h04
`define OFS_SPEED 8'h08
`define OFS_PULSE 8'h0c
`define OFS_LIMIT 8'h10
`define OFS_ALIGN 8'h14
`define OFS_STATUS 8'h18
// Control register fields
`define CTRL_METHOD_LSB 0
`define CTRL_START_BIT 3
`define CTRL_STOP_BIT 4
`define CTRL_EXTENT_BIT 5
`define CTRL_POLICY_LSB 6
`define CTRL_ANGLE_SRC_BIT 8
`define CTRL_CAP_EN_BIT 9
// Stop method codes
`define STOP_COAST 3'h0
`define STOP_RECIRC 3'h1
`define STOP_LS_BRAKE 3'h2
`define STOP_HS_BRAKE 3'h3
`define STOP_SPIN_DOWN 3'h4
`define STOP_ALIGN 3'h5
// Open-loop pulse policies
`define POL_FOLLOW 2'h0
`define POL_HIGH 2'h1
`define POL_FIRST_ONLY 2'h2
// Speed ramp step per clock and recirculation decay scaling
`define RAMP_STEP 16'h0001
`define RECIRC_SHIFT 4
// Reset value of every register and of all state
`define REG_RESET 32'h0000_0000
`endif

// ===== motor_stop_pkg.sv
// Types of the motor stop and speed pulse block
package motor_stop_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RUN, S_RECIRC, S_DECEL, S_BRAKE, S_SPIN, S_ALIGN} stop_state_t;
   typedef struct packed {
      stop_state_t st;
      logic brk_hs;
      logic pin_mode;
      logic [31:0] cnt;
      logic [15:0] speed_ref;
      logic [5:0] gate;
      logic [31:0] ctrl;
      logic [31:0] brake_time;
      logic [31:0] speed_cfg;
      logic [31:0] pulse_cfg;
      logic [31:0] limit_cfg;
      logic [31:0] align_cfg;
      logic [3:0] div_cnt;
      logic tog;
      logic pulse;
      logic later_start;
      logic ol_d;
      logic cap_lim;
      logic brk_s1;
      logic brk_s2;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } stop_regs_t;
endpackage : motor_stop_pkg

// ===== motor_stop_and_speed_pulse.sv
// Motor stop sequencer, speed pulse output and supply current cap
//
// Functional notes
// - Coast: stop switches all six switches off at once, high impedance.
// - Recirculation: turn off some switches for a computed decay, then all off.
// - Recirculation side chosen from conducting pattern when stop arrives.
// - Low-side brake: slow to entry speed, low sides on for duration, off.
// - Already below brake entry speed at stop: brake immediately, no slowing.
// - Brake pin high: slow to entry speed, low sides on until pin low.
// - High-side brake: slow to entry speed, high sides on for duration, off.
// - Spin-down: ramp speed reference to floor, then all switches off.
// - Align brake: inject DC pattern for duration, current held under align cap.
// - Align pattern from configured target or last commutation sector.
// - Align method selected: brake pin enters align brake state too.
// - Extent 0: pulse while driven; 1: pulse until back-EMF below level.
// - Pulse output divided to one pulse per N electrical cycles, N up to 15.
// - Motor lock holds speed pulse output high.
// - Policy 00: open loop pulse follows driving frequency.
// - Policy 01: pulse held high through open loop.
// - Policy 10: follow only in first start after wake, else held high.
// - Cap enabled: restrict speed reference to keep supply current under cap.
// - Supply current estimated from phase currents, phase voltages, bus voltage.
// - Status register shows whether the supply cap is limiting.
`include "motor_stop_consts.svh"
`timescale 1ns/1ps
module motor_stop_and_speed_pulse
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Estimator and modulator side
   input wire logic [5:0] drive_gate,
   input wire logic [15:0] speed_cmd,
   input wire logic [15:0] motor_speed,
   input wire logic [15:0] backemf,
   input wire logic signed [15:0] phase_i_a,
   input wire logic signed [15:0] phase_i_b,
   input wire logic signed [15:0] phase_i_c,
   input wire logic signed [15:0] phase_v_a,
   input wire logic signed [15:0] phase_v_b,
   input wire logic signed [15:0] phase_v_c,
   input wire logic [15:0] bus_voltage,
   input wire logic [2:0] last_sector,
   input wire logic elec_half,
   input wire logic open_loop,
   input wire logic motor_lock,
   input wire logic wake_event,
   // Brake pin
   input wire logic brake_pin,
   // Power stage and outputs
   output logic [5:0] gate,
   output logic [15:0] speed_ref,
   output logic speed_pulse_output,
   output logic cap_limiting,
   output motor_stop_pkg::stop_state_t motor_state
);
   import motor_stop_pkg::*;

   stop_regs_t q;
   stop_regs_t next_q;

   // Wide arithmetic for the supply current estimate
   logic signed [31:0] pw_a;
   logic signed [31:0] pw_b;
   logic signed [31:0] pw_c;
   logic signed [33:0] pw_sum;
   logic [31:0] pw_cap;
   logic over_cap;
   logic [15:0] ia_abs;
   logic [15:0] ib_abs;
   logic [15:0] ic_abs;
   logic [15:0] i_max;

   // Power balance: phase power against cap times bus voltage
   assign pw_a = phase_v_a * phase_i_a;
   assign pw_b = phase_v_b * phase_i_b;
   assign pw_c = phase_v_c * phase_i_c;
   assign pw_sum = 34'(pw_a) + 34'(pw_b) + 34'(pw_c);
   assign pw_cap = q.limit_cfg[15:0] * bus_voltage;
   assign over_cap = pw_sum > $signed({2'b00, pw_cap});

   // Largest phase current magnitude
   assign ia_abs = phase_i_a[15] ? 16'(-phase_i_a) : phase_i_a;
   assign ib_abs = phase_i_b[15] ? 16'(-phase_i_b) : phase_i_b;
   assign ic_abs = phase_i_c[15] ? 16'(-phase_i_c) : phase_i_c;
   assign i_max = (ia_abs > ib_abs) ? ((ia_abs > ic_abs) ? ia_abs : ic_abs)
                                    : ((ib_abs > ic_abs) ? ib_abs : ic_abs);

   // Next state of the whole block
   always_comb
   begin
      logic start_cmd;
      logic stop_cmd;
      logic pin_hi;
      logic [2:0] method;
      logic [2:0] sector;
      logic [5:0] align_pat;
      logic [15:0] entry_speed;
      logic [15:0] floor_speed;
      logic [3:0] div_n;
      logic driving;
      logic active;
      logic hold_high;
      start_cmd = 1'b0;
      stop_cmd = 1'b0;
      driving = 1'b0;
      active = 1'b0;
      hold_high = 1'b0;
      align_pat = 6'h00;
      next_q = q;
      pin_hi = q.brk_s2;
      method = q.ctrl[`CTRL_METHOD_LSB +: 3];
      entry_speed = q.speed_cfg[15:0];
      floor_speed = q.speed_cfg[31:16];
      div_n = (q.pulse_cfg[3:0] == 4'h0) ? 4'h1 : q.pulse_cfg[3:0];
      sector = q.ctrl[`CTRL_ANGLE_SRC_BIT] ? last_sector : q.align_cfg[2:0];
      // Align phase pattern per sector, high sides then low sides
      case (sector)
         3'h0: align_pat = 6'h23;
         3'h1: align_pat = 6'h31;
         3'h2: align_pat = 6'h15;
         3'h3: align_pat = 6'h1c;
         3'h4: align_pat = 6'h0e;
         3'h5: align_pat = 6'h2a;
         default: align_pat = 6'h23;
      endcase

      // Brake pin synchroniser
      next_q.brk_s1 = brake_pin;
      next_q.brk_s2 = q.brk_s1;

      // APB access, answered one cycle into the access phase
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
      if (psel && penable && !q.pready)
      begin
         next_q.pready = 1'b1;
         next_q.prdata = 32'h0000_0000;
         case (paddr)
            `OFS_CTRL:
            begin
               if (pwrite)
               begin
                  next_q.ctrl = pwdata & 32'h0000_03e7; // command bits are not stored
                  start_cmd = pwdata[`CTRL_START_BIT];
                  stop_cmd = pwdata[`CTRL_STOP_BIT];
               end
               else
                  next_q.prdata = q.ctrl;
            end
            `OFS_BRAKE_TIME:
               if (pwrite) next_q.brake_time = pwdata;
               else next_q.prdata = q.brake_time;
            `OFS_SPEED:
               if (pwrite) next_q.speed_cfg = pwdata;
               else next_q.prdata = q.speed_cfg;
            `OFS_PULSE:
               if (pwrite) next_q.pulse_cfg = pwdata & 32'hffff_000f;
               else next_q.prdata = q.pulse_cfg;
            `OFS_LIMIT:
               if (pwrite) next_q.limit_cfg = pwdata;
               else next_q.prdata = q.limit_cfg;
            `OFS_ALIGN:
               if (pwrite) next_q.align_cfg = pwdata & 32'h0000_0007;
               else next_q.prdata = q.align_cfg;
            `OFS_STATUS:
               if (!pwrite) next_q.prdata = {q.speed_ref, 10'h000, q.later_start, q.pulse,
                                             q.cap_lim, q.st};
            default:
               next_q.pslverr = 1'b1;
         endcase
      end

      // Supply cap flag
      next_q.cap_lim = q.ctrl[`CTRL_CAP_EN_BIT] && over_cap;

      // Stop sequencer
      case (q.st)
         S_IDLE:
         begin
            next_q.gate = 6'h00;
            next_q.speed_ref = 16'h0000;
            if (start_cmd)
               next_q.st = S_RUN;
         end
         S_RUN:
         begin
            next_q.gate = drive_gate;
            // Ramp toward command, never up while capped
            if (q.cap_lim && q.speed_ref != 16'h0000)
               next_q.speed_ref = q.speed_ref - `RAMP_STEP;
            else if (!q.cap_lim && q.speed_ref < speed_cmd)
               next_q.speed_ref = q.speed_ref + `RAMP_STEP;
            else if (q.speed_ref > speed_cmd)
               next_q.speed_ref = q.speed_ref - `RAMP_STEP;
            next_q.cnt = q.brake_time;
            next_q.pin_mode = 1'b0;
            next_q.brk_hs = 1'b0;
            if (pin_hi)
            begin
               next_q.pin_mode = 1'b1;
               if (method == `STOP_ALIGN)
                  next_q.st = S_ALIGN;
               else if (motor_speed < entry_speed)
                  next_q.st = S_BRAKE;
               else
                  next_q.st = S_DECEL;
            end
            else if (stop_cmd)
            begin
               case (method)
                  `STOP_COAST:
                  begin
                     next_q.gate = 6'h00;
                     next_q.st = S_IDLE;
                  end
                  `STOP_RECIRC:
                  begin
                     // Keep the high side when at least two high switches conduct, else the low side
                     if (32'(drive_gate[5]) + 32'(drive_gate[4]) + 32'(drive_gate[3]) >= 32'd2)
                        next_q.gate = {drive_gate[5:3], 3'b000};
                     else
                        next_q.gate = {3'b000, drive_gate[2:0]};
                     next_q.cnt = 32'(i_max >> `RECIRC_SHIFT) + 32'd1;
                     next_q.st = S_RECIRC;
                  end
                  `STOP_LS_BRAKE, `STOP_HS_BRAKE:
                  begin
                     next_q.brk_hs = (method == `STOP_HS_BRAKE);
                     if (motor_speed < entry_speed)
                        next_q.st = S_BRAKE;
                     else
                        next_q.st = S_DECEL;
                  end
                  `STOP_SPIN_DOWN:
                     next_q.st = S_SPIN;
                  `STOP_ALIGN:
                     next_q.st = S_ALIGN;
                  default:
                  begin
                     next_q.gate = 6'h00;
                     next_q.st = S_IDLE;
                  end
               endcase
            end
         end
         S_RECIRC:
         begin
            // Decay interval, then the remaining switches off
            if (q.cnt <= 32'd1)
            begin
               next_q.gate = 6'h00;
               next_q.st = S_IDLE;
            end
            else
               next_q.cnt = q.cnt - 32'd1;
         end
         S_DECEL:
         begin
            next_q.gate = drive_gate;
            if (q.speed_ref > entry_speed && motor_speed >= entry_speed)
               next_q.speed_ref = q.speed_ref - `RAMP_STEP;
            else
               next_q.st = S_BRAKE;
         end
         S_BRAKE:
         begin
            next_q.speed_ref = 16'h0000;
            if (q.pin_mode)
            begin
               if (!pin_hi)
               begin
                  next_q.gate = 6'h00;
                  next_q.st = S_RUN;
               end
            end
            else if (q.cnt <= 32'd1)
            begin
               next_q.gate = 6'h00;
               next_q.st = S_IDLE;
            end
            else
               next_q.cnt = q.cnt - 32'd1;
         end
         S_SPIN:
         begin
            next_q.gate = drive_gate;
            if (q.speed_ref > floor_speed)
               next_q.speed_ref = q.speed_ref - `RAMP_STEP;
            else
            begin
               next_q.gate = 6'h00;
               next_q.st = S_IDLE;
            end
         end
         S_ALIGN:
         begin
            next_q.speed_ref = 16'h0000;
            if (q.pin_mode)
            begin
               if (!pin_hi)
               begin
                  next_q.gate = 6'h00;
                  next_q.st = S_RUN;
               end
            end
            else if (q.cnt <= 32'd1)
            begin
               next_q.gate = 6'h00;
               next_q.st = S_IDLE;
            end
            else
               next_q.cnt = q.cnt - 32'd1;
         end
         default:
         begin
            next_q.gate = 6'h00;
            next_q.st = S_IDLE;
         end
      endcase

      // Brake and align patterns stand from the first cycle of the state
      if (next_q.st == S_BRAKE)
         next_q.gate = next_q.brk_hs ? 6'h38 : 6'h07;
      else if (next_q.st == S_ALIGN)
         next_q.gate = (i_max > q.limit_cfg[31:16]) ? 6'h00 : align_pat; // chopped above align cap

      // Pulse divider on electrical half cycles
      if (elec_half)
      begin
         if (q.div_cnt + 4'h1 >= div_n)
         begin
            next_q.div_cnt = 4'h0;
            next_q.tog = !q.tog;
         end
         else
            next_q.div_cnt = q.div_cnt + 4'h1;
      end

      // First start tracking after power-on, sleep or standby
      next_q.ol_d = open_loop;
      if (wake_event)
         next_q.later_start = 1'b0;
      else if (q.ol_d && !open_loop)
         next_q.later_start = 1'b1;

      // Speed pulse output policy
      driving = (q.st == S_RUN) || (q.st == S_DECEL) || (q.st == S_SPIN);
      active = q.ctrl[`CTRL_EXTENT_BIT] ? (backemf >= q.pulse_cfg[31:16]) : driving;
      hold_high = open_loop && ((q.ctrl[`CTRL_POLICY_LSB +: 2] == `POL_HIGH) ||
                  ((q.ctrl[`CTRL_POLICY_LSB +: 2] == `POL_FIRST_ONLY) && q.later_start));
      if (motor_lock)
         next_q.pulse = 1'b1;
      else if (!active)
         next_q.pulse = 1'b0;
      else if (hold_high)
         next_q.pulse = 1'b1;
      else
         next_q.pulse = q.tog;
   end

   // State register, frozen while the enable is low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else if (ce)
         q <= next_q;
   end

   // Outputs straight from flip-flops
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign gate = q.gate;
   assign speed_ref = q.speed_ref;
   assign speed_pulse_output = q.pulse;
   assign cap_limiting = q.cap_lim;
   assign motor_state = q.st;
endmodule : motor_stop_and_speed_pulse

// ===== motor_stop_props.sv
// Port assertions for the motor stop and speed pulse block
`timescale 1ns/1ps
module motor_stop_props
(
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Motor side
   input wire logic motor_lock,
   input wire logic [5:0] gate,
   input wire logic [15:0] speed_ref,
   input wire logic speed_pulse_output,
   input wire logic cap_limiting,
   input motor_stop_pkg::stop_state_t motor_state
);
   import motor_stop_pkg::*;
   // One clock domain
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Switch patterns per state
   a_idle_gates_off: assert property (motor_state == S_IDLE |-> gate == 6'h00)
      else $error("switches on while idle");
   a_brake_one_side: assert property (motor_state == S_BRAKE |-> gate == 6'h07 || gate == 6'h38)
      else $error("brake pattern wrong");
   a_recirc_one_side: assert property (motor_state == S_RECIRC |-> gate[5:3] == 3'h0 || gate[2:0] == 3'h0)
      else $error("recirculation on both sides");
   // Speed reference ramps
   a_decel_ramp: assert property ($past(ce) && $past(motor_state) == S_DECEL && motor_state == S_DECEL
      |-> speed_ref == $past(speed_ref) - 16'h0001)
      else $error("deceleration step wrong");
   a_spin_ramp: assert property ($past(ce) && $past(motor_state) == S_SPIN && motor_state == S_SPIN
      |-> speed_ref == $past(speed_ref) - 16'h0001)
      else $error("spin-down step wrong");
   a_cap_restrains: assert property (cap_limiting && $past(cap_limiting) && $past(ce)
      && $past(motor_state) == S_RUN && motor_state == S_RUN
      |-> speed_ref < $past(speed_ref) || speed_ref == 16'h0000)
      else $error("speed not held back by cap");
   // Lock forces the pulse output high
   a_lock_pulse_high: assert property (motor_lock [*4] |-> speed_pulse_output)
      else $error("pulse low during lock");
   // Bus answers
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_unmapped_err: assert property (psel && penable && !pready && ce && paddr > 8'h18 |=> pready && pslverr)
      else $error("unmapped access not refused");
   // Main scenarios seen
   c_brake: cover property (motor_state == S_BRAKE);
   c_recirc: cover property (motor_state == S_RECIRC);
   c_cap: cover property (cap_limiting && motor_state == S_RUN);
   c_lock: cover property (motor_lock && speed_pulse_output);
endmodule : motor_stop_props
bind motor_stop_and_speed_pulse motor_stop_props u_props(.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .motor_lock(motor_lock),
   .gate(gate), .speed_ref(speed_ref), .speed_pulse_output(speed_pulse_output),
   .cap_limiting(cap_limiting), .motor_state(motor_state));

// ===== power_stage_model.sv
// Behavioural power stage and rotor facing the stop block
`timescale 1ns/1ps
module power_stage_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Switch pattern and reference
   input wire logic [5:0] gate,
   input wire logic [15:0] speed_ref,
   // Rotor feedback
   output logic [15:0] motor_speed,
   output logic signed [15:0] phase_i,
   output logic signed [15:0] phase_v,
   output logic elec_half
);
   logic [2:0] ph;
   // Current only while a switch conducts
   assign phase_i = (gate != 6'h00) ? 16'sh0064 : 16'sh0000;
   assign phase_v = 16'sh0064;
   assign elec_half = (ph == 3'h7) && (gate != 6'h00);
   // Brake drags the rotor, else it follows the reference
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         motor_speed <= 16'h0000;
         ph <= 3'h0;
      end
      else
      begin
         ph <= ph + 3'h1;
         if (gate == 6'h07 || gate == 6'h38)
            motor_speed <= (motor_speed > 16'h0002) ? motor_speed - 16'h0002 : 16'h0000;
         else if (motor_speed < speed_ref)
            motor_speed <= motor_speed + 16'h0001;
         else if (motor_speed > speed_ref)
            motor_speed <= motor_speed - 16'h0001;
      end
   end
endmodule : power_stage_model

// ===== motor_stop_and_speed_pulse_tb.sv
// Self-checking bench of the motor stop and speed pulse block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module motor_stop_and_speed_pulse_tb;
   import motor_stop_pkg::*;
   logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, cfg, seed, d;
   logic [5:0] drive_gate, gate;
   logic [15:0] speed_cmd, motor_speed, speed_ref;
   logic signed [15:0] ph_i, ph_v;
   logic [2:0] last_sector;
   logic elec_half, open_loop, motor_lock, wake_event, brake_pin, speed_pulse_output, cap_limiting;
   stop_state_t motor_state;
   logic [38:0] eq[$], mq[$], e_n, m_n;
   int mismatches, checked, c, cyc = 0;
   int nl[4] = '{0, 1, 3, 15};
   logic [5:0] pat[6] = '{6'h23, 6'h31, 6'h15, 6'h1c, 6'h0e, 6'h2a};
   localparam logic [38:0] M_ALL = {1'b1, 6'h00, 32'hffff_ffff};
   localparam logic [38:0] M_ST = {1'b0, 6'h00, 32'h0000_0007};
   localparam logic [38:0] M_SG = {1'b0, 6'h3f, 32'h0000_0007};
   motor_stop_and_speed_pulse dut(.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_gate(drive_gate), .speed_cmd(speed_cmd), .motor_speed(motor_speed), .backemf(16'h0000),
      .phase_i_a(ph_i), .phase_i_b(ph_i), .phase_i_c(ph_i), .phase_v_a(ph_v), .phase_v_b(ph_v),
      .phase_v_c(ph_v), .bus_voltage(16'h0100), .last_sector(last_sector), .elec_half(elec_half),
      .open_loop(open_loop), .motor_lock(motor_lock), .wake_event(wake_event), .brake_pin(brake_pin),
      .gate(gate), .speed_ref(speed_ref), .speed_pulse_output(speed_pulse_output),
      .cap_limiting(cap_limiting), .motor_state(motor_state));
   power_stage_model stage(.clk(clk), .rst_b(rst_b), .gate(gate), .speed_ref(speed_ref),
      .motor_speed(motor_speed), .phase_i(ph_i), .phase_v(ph_v), .elec_half(elec_half));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Verdict and end of run
   task results;
      if (mismatches == 0 && checked > 0 && eq.size() == 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   // Cycle ceiling against hangs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         mismatches++;
         results();
      end
   end
   // Oldest note against each read answer
   always @(negedge clk)
   begin
      if (pready === 1'b1 && pwrite === 1'b0)
      begin
         e_n = eq.pop_front();
         m_n = mq.pop_front();
         `CHK({pslverr, gate, prdata} & m_n, e_n & m_n)
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [38:0] st(input logic [5:0] g, input stop_state_t s);
      return {1'b0, g, 29'h0, s};
   endfunction : st
   // One bus transfer: setup, access until ready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(negedge clk);
      while (pready !== 1'b1);
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] a, input logic [38:0] e, input logic [38:0] m);
      eq.push_back(e);
      mq.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task wait_st(input stop_state_t s);
      int i;
      i = 0;
      @(negedge clk);
      while (motor_state !== s && i < 800)
      begin
         @(negedge clk);
         i++;
      end
      `CHK(motor_state, s)
      @(posedge clk);
   endtask : wait_st
   task per(output int n);
      int k;
      logic p;
      n = 0;
      k = 0;
      p = speed_pulse_output;
      while (k < 2)
      begin
         @(negedge clk);
         k += (speed_pulse_output && !p);
         p = speed_pulse_output;
         n += (k == 1);
      end
      @(posedge clk);
   endtask : per
   task hold_hi;
      repeat (20) @(negedge clk);
      `CHK(speed_pulse_output, 1'b1)
      repeat (37) @(negedge clk);
      `CHK(speed_pulse_output, 1'b1)
      @(posedge clk);
   endtask : hold_hi
   // Start, stop with method m, follow the states through
   task stop_seq(input logic [2:0] m, input logic [15:0] ent, input stop_state_t s1, input logic [5:0] g1,
      input stop_state_t s2, input logic [5:0] g2);
      apb(1'b1, 8'h08, {16'h0010, ent});
      apb(1'b1, 8'h00, cfg | 32'h8 | {29'h0, m});
      repeat (150) @(posedge clk);
      rd(8'h18, st(drive_gate, S_RUN), M_SG);
      apb(1'b1, 8'h00, cfg | 32'h10 | {29'h0, m});
      rd(8'h18, st(g1, s1), (g1 == 6'h3f) ? M_ST : M_SG);
      wait_st(s2);
      rd(8'h18, st(g2, s2), (g2 == 6'h3f) ? M_ST : M_SG);
      wait_st(S_IDLE);
      rd(8'h18, st(6'h00, S_IDLE), M_SG);
   endtask : stop_seq
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {open_loop, motor_lock, wake_event, brake_pin, rst_b} = '0;
      ce = 1'b1;
      drive_gate = 6'h31;
      speed_cmd = 16'h0040;
      last_sector = 3'h2;
      cfg = 32'h0;
      seed = 32'h8a7e2b5d;
      mismatches = 0;
      checked = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values, unmapped place, read-back, read-only status
      for (int a = 0; a < 8; a++)
         rd(8'(a * 4), (a == 7) ? {1'b1, 38'h0} : 39'h0, M_ALL);
      for (int a = 1; a < 6; a++)
      begin
         d = xs();
         apb(1'b1, 8'(a * 4), d);
         rd(8'(a * 4), {7'h0, d}, (a == 5) ? {7'h0, 32'h7} : (a == 3) ? {7'h0, 32'hffff_000f} : M_ALL);
      end
      apb(1'b1, 8'h18, 32'hffff_ffff);
      rd(8'h18, 39'h0, M_ALL);
      apb(1'b1, 8'h04, 32'h0000_0028);
      apb(1'b1, 8'h0c, 32'h0000_0001);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      apb(1'b1, 8'h14, 32'h0000_0003);
      stop_seq(3'h0, 16'h0010, S_IDLE, 6'h00, S_IDLE, 6'h00);
      stop_seq(3'h1, 16'h0010, S_RECIRC, 6'h30, S_IDLE, 6'h00);
      stop_seq(3'h2, 16'hffff, S_BRAKE, 6'h07, S_BRAKE, 6'h07);
      stop_seq(3'h3, 16'h0010, S_DECEL, 6'h3f, S_BRAKE, 6'h38);
      stop_seq(3'h4, 16'h0010, S_SPIN, 6'h3f, S_IDLE, 6'h00);
      stop_seq(3'h5, 16'h0010, S_ALIGN, 6'h1c, S_IDLE, 6'h00);
      cfg = 32'h100;
      d = xs() % 6;
      last_sector <= 3'(d);
      stop_seq(3'h5, 16'h0010, S_ALIGN, pat[d], S_IDLE, 6'h00);
      // Supply cap limiting and released
      cfg = 32'h200;
      apb(1'b1, 8'h10, 32'hffff_0000);
      apb(1'b1, 8'h00, cfg | 32'h8);
      repeat (20) @(posedge clk);
      rd(8'h18, {1'b0, 6'h00, 32'h9}, {1'b0, 6'h00, 32'hf});
      apb(1'b1, 8'h10, 32'hffff_ffff);
      repeat (5) @(posedge clk);
      rd(8'h18, {1'b0, 6'h00, 32'h1}, {1'b0, 6'h00, 32'hf});
      // Divider settings
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, 8'h0c, nl[i]);
         per(c);
         per(c);
         `CHK(c, 16 * ((nl[i] == 0) ? 1 : nl[i]))
      end
      apb(1'b1, 8'h0c, 32'h1);
      // Open-loop policies, then motor lock
      apb(1'b1, 8'h00, 32'h240);
      open_loop <= 1'b1;
      hold_hi();
      apb(1'b1, 8'h00, 32'h200);
      per(c);
      per(c);
      `CHK(c, 16)
      apb(1'b1, 8'h00, 32'h280);
      open_loop <= 1'b0;
      wake_event <= 1'b1;
      @(posedge clk);
      wake_event <= 1'b0;
      open_loop <= 1'b1;
      per(c);
      per(c);
      `CHK(c, 16)
      open_loop <= 1'b0;
      repeat (5) @(posedge clk);
      open_loop <= 1'b1;
      hold_hi();
      open_loop <= 1'b0;
      motor_lock <= 1'b1;
      hold_hi();
      motor_lock <= 1'b0;
      // Extent on back-EMF: level above it silences the pulse
      apb(1'b1, 8'h0c, 32'h0001_0001);
      apb(1'b1, 8'h00, 32'h220);
      repeat (40)
      begin
         @(negedge clk);
         `CHK(speed_pulse_output, 1'b0)
      end
      // Brake pin with low-side and align methods
      apb(1'b1, 8'h00, 32'h202);
      brake_pin <= 1'b1;
      wait_st(S_BRAKE);
      rd(8'h18, st(6'h07, S_BRAKE), M_SG);
      repeat (100) @(posedge clk);
      rd(8'h18, st(6'h07, S_BRAKE), M_SG);
      brake_pin <= 1'b0;
      wait_st(S_RUN);
      apb(1'b1, 8'h00, 32'h205);
      brake_pin <= 1'b1;
      wait_st(S_ALIGN);
      rd(8'h18, st(6'h1c, S_ALIGN), M_SG);
      brake_pin <= 1'b0;
      wait_st(S_RUN);
      // Enable low freezes the ramping reference
      ce <= 1'b0;
      @(negedge clk);
      d = {16'h0000, speed_ref};
      repeat (30) @(posedge clk);
      `CHK(speed_ref, d[15:0])
      ce <= 1'b1;
      // Coast stop, switches stay off
      apb(1'b1, 8'h00, 32'h210);
      repeat (60) @(posedge clk);
      rd(8'h18, st(6'h00, S_IDLE), M_SG);
      repeat (4) @(posedge clk);
      results();
   end
endmodule : motor_stop_and_speed_pulse_tb
